// ===== src/ast_pkg.sv
package ast_pkg;
	// register offsets inside the control word region
	localparam logic [2:0] OFF_IRQ_STATUS = 3'h0;
	localparam logic [2:0] OFF_SCAN_CTRL = 3'h2;
	localparam logic [2:0] OFF_TRIG_CTRL = 3'h4;
	// offsets inside the sample-data word region
	localparam logic [2:0] OFF_DAT_SAMPLE = 3'h0;
	localparam logic [2:0] OFF_DAT_CLEAR = 3'h2;
	// reset values of the control registers
	localparam logic [15:0] SCAN_RESET = 16'h0000;
	localparam logic [15:0] TRIG_RESET = 16'h0000;
	// interrupt / fifo status register bits
	localparam int BIT_INT_CLEAR = 7;
	localparam int BIT_OVF_CLEAR = 13;
	localparam int BIT_DRAIN_CLEAR = 14;
	localparam int BIT_EXT_IRQ = 8;
	localparam int BIT_BURST_DONE = 9;
	localparam int BIT_HALF = 10;
	localparam int BIT_AVAIL_LATCHED = 11;
	localparam int BIT_AVAIL_LIVE = 12;
	localparam int BIT_OVERFLOW = 13;
	localparam int BIT_DRAINED = 14;
	// scan control fields
	localparam int SCAN_FIELD_W = 14;
	localparam int BIT_EOC = 14;
	// trigger control fields
	localparam int TRIG_SRC_LSB = 0;
	localparam int BIT_TRIG_INV = 2;
	localparam int BIT_TRIG_EDGE = 3;
	localparam int BIT_TRIG_EN = 4;
	localparam int BIT_BURST_EN = 5;
	localparam int BIT_PRETRIG = 6;
	localparam int BIT_TRIG_CLEAR = 7;
	localparam int BIT_ARM = 11;
	localparam int BIT_FIFO_MODE = 12;
	localparam int BIT_TRIG_LATCH = 7;
	// documented depth of the sample store, in words
	localparam int DOC_FIFO_WORDS = 512;
	// pacer sources
	typedef enum logic [1:0] {
		PACE_SOFT = 2'h0,
		PACE_TIMER = 2'h1,
		PACE_EXT_FALL = 2'h2,
		PACE_EXT_RISE = 2'h3
	} ast_pacer_e;
	// trigger sources
	typedef enum logic [1:0] {
		TRIG_OFF = 2'h0,
		TRIG_SOFT = 2'h1,
		TRIG_EXT_DIG = 2'h2,
		TRIG_EXT_ANA = 2'h3
	} ast_trig_src_e;
	// full-scale spans 10V, 5V, 2.5V, 1.25V
	typedef enum logic [1:0] {
		SPAN_10V = 2'h0,
		SPAN_5V = 2'h1,
		SPAN_2V5 = 2'h2,
		SPAN_1V25 = 2'h3
	} ast_span_e;
	// acquisition sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONVERT = 3'h2,
		ST_BURST = 3'h4
	} ast_state_e;
	// scan / range / pacer control word, bit 13 down to bit 0
	typedef struct packed {
		ast_pacer_e pacer;
		logic unipolar;
		logic single_ended;
		ast_span_e span;
		logic [3:0] last;
		logic [3:0] first;
	} ast_scan_s;
	// one host word access
	typedef struct packed {
		logic ctl_sel;
		logic dat_sel;
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [15:0] wdata;
	} ast_io_req_s;
endpackage

// ===== src/ast_core.sv
`timescale 1ns/1ps
// What this block does
// - latch external interrupt on rising input edge
// - latch end of burst when burst completes
// - latch half-full once at or above half capacity
// - latch not-empty when a word becomes readable
// - live not-empty flag follows stored words
// - latch overflow when writing into full store
// - latch output-store drained event
// - channel write loads first, step, wrap after last
// - span field selects gain 1, 2, 4, 8
// - mode bit: single-ended 16, differential 8 channels
// - polarity bit selects unipolar or bipolar
// - pacer field: soft, timer, falling, rising edge
// - sample-offset data write starts soft conversion
// - live conversion-done bit, low while busy
// - trigger source: off, soft, digital, analog
// - invert external trigger when polarity set
// - edge select picks edge trigger or level gate
// - external source acts only while enabled
// - first edge sets latch, later ones ignored
// - burst mode converts from current channel through last
// - pre-trigger enable with arm and mode bits
// - overflow clear writes one, zero no effect
// - trigger clear writes one, zero no effect

// sample store: flip-flop ring with valid/ready on both sides
module ast_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
	logic [PW-1:0] wr_q; // write index
	logic [PW-1:0] rd_q; // read index
	logic [CW-1:0] cnt_q; // words held
	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	assign o_in_ready = (cnt_q != FULL_CNT);
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];
	assign o_count = cnt_q;

	// index step with wrap at the last slot
	function automatic logic [PW-1:0] step(input logic [PW-1:0] idx);
		step = (idx == LAST_IDX) ? '0 : idx + PW'(1);
	endfunction

	// pointer and count update, flush wins
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (i_flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= step(wr_q);
			if (pop) rd_q <= step(rd_q);
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end

	// data words, no reset needed
	always_ff @(posedge i_clk) begin
		if (push) mem_q[wr_q] <= i_in_data;
	end
endmodule // ast_fifo

// acquisition control, trigger and status registers
module ast_core
	import ast_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int DATA_W = 16
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire ast_io_req_s i_io_req,
	output logic [15:0] o_io_rdata,
	input wire logic i_ext_irq,
	input wire logic i_timer_tick,
	input wire logic i_ext_pacer,
	input wire logic i_ext_trig,
	input wire logic i_ana_trig,
	input wire logic i_out_fifo_drained,
	output logic o_conv_start,
	input wire logic i_conv_busy,
	input wire logic i_conv_valid,
	input wire logic [DATA_W-1:0] i_conv_data,
	output logic [3:0] o_mux_channel,
	output logic [3:0] o_gain,
	output logic o_unipolar,
	output logic o_single_ended,
	output logic o_pretrig_enable,
	output logic o_arm,
	output logic o_fifo_mode
);
	localparam int CW = $clog2(FIFO_DEPTH+1);
	localparam logic [CW-1:0] HALF_CNT = CW'(FIFO_DEPTH / 2);

	// control registers
	ast_scan_s scan_q; // scan, range, pacer
	ast_trig_src_e trig_src_q; // trigger source
	logic trig_inv_q; // external input inverted
	logic trig_edge_q; // edge, else level gate
	logic trig_en_q; // external source enable
	logic burst_en_q; // burst mode
	logic pretrig_q; // pre-trigger mode
	logic arm_q; // arm bit
	logic fifo_mode_q; // fifo mode bit
	// latched status
	logic ext_irq_latched_q;
	logic burst_done_latched_q;
	logic half_latched_q;
	logic avail_latched_q;
	logic overflow_q;
	logic drained_latched_q;
	logic trig_latch_q;
	// history for edge detection
	logic ext_irq_prev_q;
	logic pacer_prev_q;
	logic trig_prev_q;
	// sequencer
	ast_state_e state_q;
	ast_state_e state_d;
	logic [3:0] chan_q; // current mux channel
	logic start_q; // conversion start pulse
	logic [15:0] rdata_q; // read answer

	// fifo hookup
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic [CW-1:0] fifo_count;

	// rising edge of a sampled level
	function automatic logic rise(input logic cur, input logic prev);
		rise = cur && !prev;
	endfunction

	// span code to gain 1, 2, 4, 8
	function automatic logic [3:0] span_gain(input ast_span_e sp);
		span_gain = 4'h1 << sp;
	endfunction

	// host access decode
	wire ctl_wr = i_io_req.ctl_sel && i_io_req.wr;
	wire wr_status = ctl_wr && (i_io_req.addr == OFF_IRQ_STATUS);
	wire wr_scan = ctl_wr && (i_io_req.addr == OFF_SCAN_CTRL);
	wire wr_trig = ctl_wr && (i_io_req.addr == OFF_TRIG_CTRL);
	wire dat_wr = i_io_req.dat_sel && i_io_req.wr;
	wire soft_convert = dat_wr && (i_io_req.addr == OFF_DAT_SAMPLE);
	wire fifo_clear = dat_wr && (i_io_req.addr == OFF_DAT_CLEAR);
	wire fifo_read = i_io_req.dat_sel && i_io_req.rd && (i_io_req.addr == OFF_DAT_SAMPLE);
	wire [15:0] wd = i_io_req.wdata;

	// write-one clears, zero has no effect
	wire clr_int = wr_status && wd[BIT_INT_CLEAR];
	wire clr_ovf = wr_status && wd[BIT_OVF_CLEAR];
	wire clr_drain = wr_status && wd[BIT_DRAIN_CLEAR];
	wire clr_trig = wr_trig && wd[BIT_TRIG_CLEAR];

	// trigger conditioning
	wire trig_raw = (trig_src_q == TRIG_EXT_ANA) ? i_ana_trig : i_ext_trig;
	wire trig_cond = trig_raw ^ trig_inv_q;
	wire trig_ext = (trig_src_q == TRIG_EXT_DIG) || (trig_src_q == TRIG_EXT_ANA);
	wire trig_edge_hit = trig_ext && trig_en_q && trig_edge_q
		&& rise(trig_cond, trig_prev_q);
	// gate: off blocks, soft runs, external by latch or level
	wire ext_gate = trig_en_q && (trig_edge_q ? trig_latch_q : trig_cond);
	wire gate_open = (trig_src_q == TRIG_SOFT) || (trig_ext && ext_gate);

	// pacer selection
	wire pace_fall = !i_ext_pacer && pacer_prev_q;
	wire pace_rise = rise(i_ext_pacer, pacer_prev_q);
	wire pace_sel = (scan_q.pacer == PACE_SOFT) ? soft_convert :
		(scan_q.pacer == PACE_TIMER) ? i_timer_tick :
		(scan_q.pacer == PACE_EXT_FALL) ? pace_fall : pace_rise;
	wire pace_tick = pace_sel && gate_open;

	// scan stepping
	wire at_last = (chan_q == scan_q.last);
	wire [3:0] chan_mask = scan_q.single_ended ? 4'hf : 4'h7;
	wire [3:0] chan_next = at_last ? scan_q.first : chan_q + 4'h1;
	wire burst_end = (state_q == ST_BURST) && i_conv_valid && at_last;

	// store entry: drop and flag when full
	wire push_ok = i_conv_valid && fifo_in_ready;
	wire push_lost = i_conv_valid && !fifo_in_ready;

	ast_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_flush(fifo_clear),
		.i_in_valid(i_conv_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_conv_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_read),
		.o_out_data(fifo_out_data),
		.o_count(fifo_count)
	);

	// sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (pace_tick && !i_conv_busy) begin
					state_d = burst_en_q ? ST_BURST : ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (i_conv_valid) state_d = ST_IDLE;
			end
			ST_BURST: begin
				if (burst_end) state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// start pulse: on pace from idle, and per step within a burst
	wire start_d = ((state_q == ST_IDLE) && (state_d != ST_IDLE))
		|| ((state_q == ST_BURST) && i_conv_valid && !at_last);

	// sequencer and start register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= ST_IDLE;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
		end
	end

	// channel pointer: load on write, step per result
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			chan_q <= 4'h0;
		end else if (wr_scan) begin
			chan_q <= wd[3:0];
		end else if (i_conv_valid) begin
			chan_q <= chan_next;
		end
	end

	// control register writes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scan_q <= ast_scan_s'(SCAN_RESET[SCAN_FIELD_W-1:0]);
			trig_src_q <= ast_trig_src_e'(TRIG_RESET[TRIG_SRC_LSB +: 2]);
			trig_inv_q <= TRIG_RESET[BIT_TRIG_INV];
			trig_edge_q <= TRIG_RESET[BIT_TRIG_EDGE];
			trig_en_q <= TRIG_RESET[BIT_TRIG_EN];
			burst_en_q <= TRIG_RESET[BIT_BURST_EN];
			pretrig_q <= TRIG_RESET[BIT_PRETRIG];
			arm_q <= TRIG_RESET[BIT_ARM];
			fifo_mode_q <= TRIG_RESET[BIT_FIFO_MODE];
		end else begin
			if (wr_scan) scan_q <= ast_scan_s'(wd[SCAN_FIELD_W-1:0]);
			if (wr_trig) begin
				trig_src_q <= ast_trig_src_e'(wd[TRIG_SRC_LSB +: 2]);
				trig_inv_q <= wd[BIT_TRIG_INV];
				trig_edge_q <= wd[BIT_TRIG_EDGE];
				trig_en_q <= wd[BIT_TRIG_EN];
				burst_en_q <= wd[BIT_BURST_EN];
				pretrig_q <= wd[BIT_PRETRIG];
				arm_q <= wd[BIT_ARM];
				fifo_mode_q <= wd[BIT_FIFO_MODE];
			end
		end
	end

	// input history for edges
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_irq_prev_q <= 1'b0;
			pacer_prev_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			ext_irq_prev_q <= i_ext_irq;
			pacer_prev_q <= i_ext_pacer;
			trig_prev_q <= trig_cond;
		end
	end

	// trigger latch: set wins over clear, held once set
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trig_latch_q <= 1'b0;
		end else if (trig_edge_hit) begin
			trig_latch_q <= 1'b1;
		end else if (clr_trig) begin
			trig_latch_q <= 1'b0;
		end
	end

	// sticky status bits, event beats clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_irq_latched_q <= 1'b0;
			burst_done_latched_q <= 1'b0;
			half_latched_q <= 1'b0;
			overflow_q <= 1'b0;
			drained_latched_q <= 1'b0;
		end else begin
			if (rise(i_ext_irq, ext_irq_prev_q)) ext_irq_latched_q <= 1'b1;
			else if (clr_int) ext_irq_latched_q <= 1'b0;
			if (burst_end && burst_en_q) burst_done_latched_q <= 1'b1;
			else if (clr_int) burst_done_latched_q <= 1'b0;
			if (fifo_count >= HALF_CNT) half_latched_q <= 1'b1;
			else if (clr_int) half_latched_q <= 1'b0;
			if (push_lost) overflow_q <= 1'b1;
			else if (clr_ovf) overflow_q <= 1'b0;
			if (i_out_fifo_drained) drained_latched_q <= 1'b1;
			else if (clr_drain) drained_latched_q <= 1'b0;
		end
	end

	// not-empty latch: set on entry, dropped on empty, clear or new start
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			avail_latched_q <= 1'b0;
		end else if (push_ok && !fifo_clear) begin
			avail_latched_q <= 1'b1;
		end else if (!fifo_out_valid || fifo_clear || clr_int || start_q) begin
			avail_latched_q <= 1'b0;
		end
	end

	// read words, spare bits zero
	wire [15:0] rd_status = (16'(ext_irq_latched_q) << BIT_EXT_IRQ)
		| (16'(burst_done_latched_q) << BIT_BURST_DONE)
		| (16'(half_latched_q) << BIT_HALF)
		| (16'(avail_latched_q) << BIT_AVAIL_LATCHED)
		| (16'(fifo_out_valid) << BIT_AVAIL_LIVE)
		| (16'(overflow_q) << BIT_OVERFLOW)
		| (16'(drained_latched_q) << BIT_DRAINED);
	wire conv_done = !i_conv_busy && (state_q == ST_IDLE);
	wire [15:0] rd_scan = 16'(conv_done) << BIT_EOC;
	wire [15:0] rd_trig = 16'(trig_latch_q) << BIT_TRIG_LATCH;
	wire [15:0] rd_ctl = (i_io_req.addr == OFF_IRQ_STATUS) ? rd_status :
		(i_io_req.addr == OFF_SCAN_CTRL) ? rd_scan :
		(i_io_req.addr == OFF_TRIG_CTRL) ? rd_trig : 16'h0000;
	wire [15:0] rd_dat = fifo_out_valid ? 16'(fifo_out_data) : 16'h0000;

	// read answer register, one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_q <= 16'h0000;
		end else if (i_io_req.rd && i_io_req.ctl_sel) begin
			rdata_q <= rd_ctl;
		end else if (fifo_read) begin
			rdata_q <= rd_dat;
		end
	end

	// outputs
	assign o_io_rdata = rdata_q;
	assign o_conv_start = start_q;
	assign o_mux_channel = chan_q & chan_mask;
	assign o_gain = span_gain(scan_q.span);
	assign o_unipolar = scan_q.unipolar;
	assign o_single_ended = scan_q.single_ended;
	assign o_pretrig_enable = pretrig_q;
	assign o_arm = arm_q;
	assign o_fifo_mode = fifo_mode_q;
endmodule // ast_core

// ===== testbench/ast_core_asserts.sv
`timescale 1ns/1ps
// port-level checks of the acquisition core
module ast_core_chk
	import ast_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire ast_io_req_s i_io_req,
	input wire logic i_conv_busy,
	input wire logic i_conv_valid,
	input wire logic [15:0] o_io_rdata,
	input wire logic o_conv_start,
	input wire logic [3:0] o_mux_channel,
	input wire logic [3:0] o_gain,
	input wire logic o_unipolar,
	input wire logic o_single_ended,
	input wire logic o_pretrig_enable,
	input wire logic o_arm,
	input wire logic o_fifo_mode
);
	// decoded host accesses
	wire ctl_wr = i_io_req.ctl_sel && i_io_req.wr;
	wire ctl_rd = i_io_req.ctl_sel && i_io_req.rd;
	wire [15:0] wd = i_io_req.wdata;
	wire scan_wr = ctl_wr && i_io_req.addr == OFF_SCAN_CTRL;
	wire trig_wr = ctl_wr && i_io_req.addr == OFF_TRIG_CTRL;
	// write fields as the registers should take them
	wire [1:0] span_w = wd[9:8];
	wire [1:0] mode_w = wd[11:10];
	wire [3:0] chan_w = wd[10] ? wd[3:0] : {1'b0, wd[2:0]};
	wire [2:0] trg_w = {wd[12], wd[11], wd[6]};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
		else $error("start pulse too long");
	a_start_idle: assert property (o_conv_start |-> !$past(i_conv_busy))
		else $error("start while converter busy");
	a_span_gain: assert property (scan_wr |=> o_gain == 4'h1 << $past(span_w))
		else $error("gain does not follow span");
	a_mode_bits: assert property (scan_wr |=>
		{o_unipolar, o_single_ended} == $past(mode_w))
		else $error("mode bits wrong");
	a_mux_load: assert property (scan_wr && !i_conv_valid |=>
		o_mux_channel == $past(chan_w))
		else $error("channel not loaded from first field");
	a_pretrig_bits: assert property (trig_wr |=>
		{o_fifo_mode, o_arm, o_pretrig_enable} == $past(trg_w))
		else $error("pre-trigger bits wrong");
	a_eoc_busy: assert property (ctl_rd && i_conv_busy &&
		i_io_req.addr == OFF_SCAN_CTRL |=> o_io_rdata == 16'h0000)
		else $error("done bit set while busy");
	a_unmapped_zero: assert property (ctl_rd && i_io_req.addr == 3'h6 |=>
		o_io_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_status_spare: assert property (ctl_rd && i_io_req.addr == OFF_IRQ_STATUS |=>
		o_io_rdata[7:0] == 8'h00 && !o_io_rdata[15])
		else $error("spare status bits set");
endmodule // ast_core_chk

bind ast_core ast_core_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_io_req(i_io_req),
	.i_conv_busy(i_conv_busy), .i_conv_valid(i_conv_valid), .o_io_rdata(o_io_rdata),
	.o_conv_start(o_conv_start), .o_mux_channel(o_mux_channel), .o_gain(o_gain),
	.o_unipolar(o_unipolar), .o_single_ended(o_single_ended),
	.o_pretrig_enable(o_pretrig_enable), .o_arm(o_arm), .o_fifo_mode(o_fifo_mode));

// ===== testbench/ast_conv_model.sv
`timescale 1ns/1ps
// converter stand-in: busy after a start, one result strobe later
module ast_conv_model #(
	parameter int LAT = 3
) (
	input wire logic i_clk,
	input wire logic i_start,
	output logic o_busy,
	output logic o_valid,
	output logic [15:0] o_data
);
	int cnt_q = 0; // cycles left
	logic [15:0] seq_q = 16'ha000; // next result
	logic busy_q = 1'b0; // converting
	logic valid_q = 1'b0; // result strobe
	logic [15:0] data_q = 16'h5aa5; // result bus
	assign o_busy = busy_q;
	assign o_valid = valid_q;
	assign o_data = data_q;
	// data only steady with the strobe, else toggling
	always @(posedge i_clk) begin
		valid_q <= 1'b0;
		data_q <= ~data_q;
		if (i_start === 1'b1) begin
			cnt_q <= LAT;
			busy_q <= 1'b1;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			busy_q <= 1'b0;
			valid_q <= 1'b1;
			data_q <= seq_q;
			seq_q <= seq_q + 16'h0001;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end
	end
endmodule // ast_conv_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
// bench: host word accesses against a converter model
module tb;
	import ast_pkg::*;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	ast_io_req_s req = '0;
	logic ext_irq = 1'b0;
	logic tick = 1'b0;
	logic ext_trig = 1'b0;
	logic drained = 1'b0;
	logic ext_pacer = 1'b0; // external pacer pin
	logic ana_trig = 1'b0; // analog comparator level
	logic [15:0] rdata, cdata;
	logic start, busy, valid;
	logic [3:0] mux, gain;
	logic pol, se; // polarity and input mode outputs
	logic [2:0] pre; // fifo mode, arm, pre-trigger outputs
	int fails = 0;
	int checks_done = 0;
	int starts = 0;
	ast_core uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_io_req(req), .o_io_rdata(rdata),
		.i_ext_irq(ext_irq), .i_timer_tick(tick), .i_ext_pacer(ext_pacer),
		.i_ext_trig(ext_trig), .i_ana_trig(ana_trig), .i_out_fifo_drained(drained),
		.o_conv_start(start), .i_conv_busy(busy), .i_conv_valid(valid), .i_conv_data(cdata),
		.o_mux_channel(mux), .o_gain(gain), .o_unipolar(pol), .o_single_ended(se),
		.o_pretrig_enable(pre[0]), .o_arm(pre[1]), .o_fifo_mode(pre[2]));
	ast_conv_model conv (.i_clk(i_clk), .i_start(start), .o_busy(busy), .o_valid(valid),
		.o_data(cdata));
	// 10 MHz clock
	initial begin
		forever #50 i_clk = ~i_clk;
	end
	// count conversion starts
	always @(posedge i_clk) begin
		if (start === 1'b1) begin
			starts <= starts + 1;
		end
	end
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one compare
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one word access, strobe held for one edge
	task automatic acc(input logic c, input logic w, input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk);
		req <= {c, ~c, w, ~w, a, d};
		@(posedge i_clk);
		req <= '0;
		#1;
	endtask
	task automatic wr(input logic c, input logic [2:0] a, input logic [15:0] d);
		acc(c, 1'b1, a, d);
	endtask
	task automatic rd(input logic c, input logic [2:0] a, input logic [15:0] exp);
		acc(c, 1'b0, a, 16'h0000);
		chk(rdata, exp);
	endtask
	// wait for n starts in all and converter idle
	task automatic settle(input int n);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge i_clk);
			#1;
			if (starts == n && busy === 1'b0 && valid === 1'b0) begin
				break;
			end
		end
		if (i == 60) begin
			fails++;
			$display("unexpected at %0t: converter wait ran out", $time);
			final_report();
		end
		@(posedge i_clk);
		#1;
	endtask
	// software convert, data ignored
	task automatic conv1();
		int s;
		s = starts;
		wr(1'b0, OFF_DAT_SAMPLE, 16'h5a5a);
		settle(s + 1);
	endtask
	// one timer pulse, count starts it made
	task automatic pace(input int exp);
		int s;
		s = starts;
		@(posedge i_clk);
		tick <= 1'b1;
		@(posedge i_clk);
		tick <= 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		chk(16'(starts - s), 16'(exp));
	endtask
	// raw pulse: falling edge is the inverted rising one
	task automatic trig_pulse();
		@(posedge i_clk);
		ext_trig <= 1'b1;
		repeat (2) @(posedge i_clk);
		ext_trig <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask
	initial begin
		int i;
		repeat (5) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(1'b1, OFF_IRQ_STATUS, 16'h0000);
		rd(1'b1, OFF_SCAN_CTRL, 16'h4000);
		rd(1'b1, OFF_TRIG_CTRL, 16'h0000);
		rd(1'b1, 3'h6, 16'h0000);
		@(posedge i_clk);
		ext_irq <= 1'b1;
		drained <= 1'b1;
		@(posedge i_clk);
		drained <= 1'b0;
		rd(1'b1, OFF_IRQ_STATUS, 16'h4100);
		wr(1'b1, OFF_IRQ_STATUS, 16'h4080);
		rd(1'b1, OFF_IRQ_STATUS, 16'h0000);
		$display("test latches done");
		// span, polarity and mode sweep
		for (i = 0; i < 4; i++) begin
			wr(1'b1, OFF_SCAN_CTRL, 16'((i << 8) | (i << 10) | 9));
			@(posedge i_clk);
			#1;
			chk({12'h000, gain}, 16'h1 << i);
			chk({12'h000, mux}, (i & 1) ? 16'h0009 : 16'h0001);
			chk({14'h0, pol, se}, 16'(i));
		end
		$display("test fields done");
		wr(1'b1, OFF_TRIG_CTRL, 16'h0000);
		wr(1'b1, OFF_SCAN_CTRL, 16'h0442);
		i = starts;
		wr(1'b0, OFF_DAT_SAMPLE, 16'h5a5a);
		repeat (4) @(posedge i_clk);
		#1;
		chk(16'(starts - i), 16'h0000);
		wr(1'b1, OFF_TRIG_CTRL, 16'h0001);
		chk({12'h000, mux}, 16'h0002);
		i = starts;
		wr(1'b0, OFF_DAT_SAMPLE, 16'h5a5a);
		rd(1'b1, OFF_SCAN_CTRL, 16'h0000);
		settle(i + 1);
		chk({12'h000, mux}, 16'h0003);
		conv1();
		chk({12'h000, mux}, 16'h0004);
		conv1();
		chk({12'h000, mux}, 16'h0002);
		rd(1'b1, OFF_IRQ_STATUS, 16'h1800);
		for (i = 0; i < 3; i++) begin
			rd(1'b0, OFF_DAT_SAMPLE, 16'(16'ha000 + i));
		end
		rd(1'b1, OFF_IRQ_STATUS, 16'h0000);
		$display("test scan done");
		// fill past full, clear overflow, flush
		for (i = 0; i < 17; i++) begin
			conv1();
			if (i == 6) begin
				rd(1'b1, OFF_IRQ_STATUS, 16'h1800);
			end
			if (i == 7) begin
				rd(1'b1, OFF_IRQ_STATUS, 16'h1c00);
			end
		end
		rd(1'b1, OFF_IRQ_STATUS, 16'h3400);
		wr(1'b1, OFF_IRQ_STATUS, 16'h2000);
		rd(1'b1, OFF_IRQ_STATUS, 16'h1400);
		wr(1'b0, OFF_DAT_CLEAR, 16'h0000);
		rd(1'b1, OFF_IRQ_STATUS, 16'h0400);
		wr(1'b1, OFF_IRQ_STATUS, 16'h0080);
		rd(1'b1, OFF_IRQ_STATUS, 16'h0000);
		$display("test fill done");
		// inverted edge trigger, enable off then on
		wr(1'b1, OFF_TRIG_CTRL, 16'h0000);
		wr(1'b1, OFF_SCAN_CTRL, 16'h1442);
		wr(1'b1, OFF_TRIG_CTRL, 16'h000e);
		trig_pulse();
		rd(1'b1, OFF_TRIG_CTRL, 16'h0000);
		pace(0);
		wr(1'b1, OFF_TRIG_CTRL, 16'h001e);
		trig_pulse();
		rd(1'b1, OFF_TRIG_CTRL, 16'h0080);
		pace(1);
		trig_pulse();
		pace(1);
		wr(1'b1, OFF_TRIG_CTRL, 16'h009e);
		rd(1'b1, OFF_TRIG_CTRL, 16'h0000);
		pace(0);
		// level gate follows the inverted input
		wr(1'b1, OFF_TRIG_CTRL, 16'h0016);
		pace(1);
		@(posedge i_clk);
		ext_trig <= 1'b1;
		pace(0);
		// analog source ignores the digital input
		wr(1'b1, OFF_TRIG_CTRL, 16'h0013);
		pace(0);
		@(posedge i_clk);
		{ext_trig, ana_trig} <= 2'b01;
		pace(1);
		@(posedge i_clk);
		ana_trig <= 1'b0;
		$display("test trigger done");
		// burst over channels 2..4 from one pulse
		wr(1'b1, OFF_TRIG_CTRL, 16'h1840);
		chk({13'h0, pre}, 16'h0007);
		wr(1'b0, OFF_DAT_CLEAR, 16'h0000);
		wr(1'b1, OFF_IRQ_STATUS, 16'h0080);
		wr(1'b1, OFF_SCAN_CTRL, 16'h1442);
		wr(1'b1, OFF_TRIG_CTRL, 16'h0021);
		i = starts;
		@(posedge i_clk);
		tick <= 1'b1;
		@(posedge i_clk);
		tick <= 1'b0;
		settle(i + 3);
		rd(1'b1, OFF_IRQ_STATUS, 16'h1a00);
		$display("test burst done");
		// external pacer: falling edge mode, then rising edge mode
		wr(1'b1, OFF_TRIG_CTRL, 16'h0000);
		wr(1'b1, OFF_SCAN_CTRL, 16'h2442);
		wr(1'b1, OFF_TRIG_CTRL, 16'h0001);
		i = starts;
		@(posedge i_clk);
		ext_pacer <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk(16'(starts - i), 16'h0000);
		@(posedge i_clk);
		ext_pacer <= 1'b0;
		settle(i + 1);
		wr(1'b1, OFF_SCAN_CTRL, 16'h3442);
		@(posedge i_clk);
		ext_pacer <= 1'b1;
		settle(i + 2);
		@(posedge i_clk);
		ext_pacer <= 1'b0;
		$display("test pacer done");
		final_report();
	end
endmodule // tb
